//--- inc/igpo_defs.svh
// Constants of the serial select and event output block.
// Assumes a 50 MHz clock; included by bare name.
`ifndef IGPO_DEFS_SVH
`define IGPO_DEFS_SVH

`define IGPO_CLK_PERIOD_NS   20
`define IGPO_FILTER_NS       80
`define IGPO_FILTER_CYC      ((`IGPO_FILTER_NS + `IGPO_CLK_PERIOD_NS - 1) / `IGPO_CLK_PERIOD_NS)
`define IGPO_WRITE_MS        5
`define IGPO_WRITE_CYC       ((`IGPO_WRITE_MS * 1000000) / `IGPO_CLK_PERIOD_NS)
`define IGPO_BULK_WRITE_MS   90
`define IGPO_BULK_WRITE_CYC  ((`IGPO_BULK_WRITE_MS * 1000000) / `IGPO_CLK_PERIOD_NS)
`define IGPO_PULSE_US        540
`define IGPO_PULSE_CYC       ((`IGPO_PULSE_US * 1000) / `IGPO_CLK_PERIOD_NS)

`define IGPO_SELECT_CODE     7'h56

`define IGPO_OFS_CFG         8'h00
`define IGPO_OFS_CMD         8'h04
`define IGPO_OFS_STAT        8'h08
`define IGPO_OFS_MASK        8'h0C
`define IGPO_OFS_STATE       8'h10
`define IGPO_OFS_TXD         8'h14
`define IGPO_OFS_RXD         8'h18

`define IGPO_CFG_RST         8'h00
`define IGPO_MASK_RST        5'h00
`define IGPO_TXD_RST         8'h00

`define IGPO_MODE_SESSION    4'h1
`define IGPO_MODE_WIP        4'h2
`define IGPO_MODE_ANSWER     4'h3
`define IGPO_MODE_INTR       4'h4

`define IGPO_CMD_I2C_SESS    0
`define IGPO_CMD_I2C_REL     1
`define IGPO_CMD_RF_SESS     2
`define IGPO_CMD_RF_DESEL    3
`define IGPO_CMD_I2C_WRITE   4
`define IGPO_CMD_RF_WRITE    5
`define IGPO_CMD_ANSWER      6
`define IGPO_CMD_I2C_INTR    7
`define IGPO_CMD_RF_INTR     8
`define IGPO_CMD_RF_MSG      9

`define IGPO_ST_ADDR         0
`define IGPO_ST_BYTE         1
`define IGPO_ST_STOP         2
`define IGPO_ST_WDONE        3
`define IGPO_ST_PDONE        4

`endif

//--- inc/igpo_pkg.sv
// Types of the serial select and event output block.
// Assumes nothing beyond the compile order.
package igpo_pkg;

  typedef enum logic [2:0] {
    IGPO_IDLE,
    IGPO_ADDR,
    IGPO_ADDR_ACK,
    IGPO_WR_BYTE,
    IGPO_WR_ACK,
    IGPO_RD_BYTE,
    IGPO_RD_ACK
  } igpo_state_t;

  typedef logic [3:0] igpo_mode_t;

endpackage

//--- inc/igpo_line_if.sv
// Filtered serial lines passed from the input filter to the core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface igpo_line_if;
  logic scl;
  logic sda;
  modport filt (output scl, output sda);
  modport core (input scl, input sda);
endinterface

//--- rtl/igpo_filter.sv
// Two-line synchroniser and glitch filter for the serial pins.
// Assumes pins are asynchronous to clk and idle high.
`timescale 1ns/1ps
`include "igpo_defs.svh"
module igpo_filter #(
  parameter int FILT_CYC = `IGPO_FILTER_CYC
) (
  input  wire logic   clk,        // System clock
  input  wire logic   reset_n,    // Async reset, active low
  input  wire logic   scl_pin,    // Raw clock pin
  input  wire logic   sda_pin,    // Raw data pin
  igpo_line_if.filt   lines       // Filtered levels
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] out_r;
  logic [3:0] cnt_r [2];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
    end else begin
      meta_r <= {sda_pin, scl_pin};
      sync_r <= meta_r;
    end
  end

  // Level changes only after it differs for more than FILT_CYC samples
  for (genvar i = 0; i < 2; i++) begin : g_ch
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_r[i] <= 4'h0;
        out_r[i] <= 1'b1;
      end else if (sync_r[i] == out_r[i]) begin
        cnt_r[i] <= 4'h0;
      end else if (cnt_r[i] == 4'(FILT_CYC)) begin
        cnt_r[i] <= 4'h0;
        out_r[i] <= sync_r[i];
      end else begin
        cnt_r[i] <= cnt_r[i] + 4'h1;
      end
    end
  end

  assign lines.scl = out_r[0];
  assign lines.sda = out_r[1];
endmodule

//--- rtl/igpo_top.sv
// Serial slave select logic with a configurable open-drain event output.
// Assumes an APB master on clk, and serial pins with external pull-ups.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "igpo_defs.svh"
// Notes on behaviour
// - The select byte must carry the fixed pattern in b7..b1 and the direction in b0, else it is ignored.
// - Every serial byte, the select byte included, moves most significant bit first.
// - The low nibble of the output setting picks the wired event and the high nibble the contactless event.
// - In session mode the output is low while the chosen side holds a session, released on release or deselect.
// - In write mode the output is low for the 5 ms programming time of an update, then released.
// - In wired answer mode the output goes low once an answer is computed and ready to fetch.
// - In wired answer and wired interrupt modes the output is released when a matching select byte has been received.
// - In contactless message mode the output is low while an update changes the message.
// - An interrupt command pulls the output low, wired until the next command, contactless for 540 us.
// - A page takes up to 5 ms and a bulk write up to 90 ms, and the master allows for it; the code times every update as one 5 ms page.
// - Pulses of 80 ns or less on the serial inputs are ignored.
module igpo_top #(
  parameter int WRITE_CYC = `IGPO_WRITE_CYC,
  parameter int PULSE_CYC = `IGPO_PULSE_CYC,
  parameter int FILT_CYC  = `IGPO_FILTER_CYC
) (
  input  wire logic        clk,              // 50 MHz clock
  input  wire logic        reset_n,          // Async reset, active low
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB direction
  input  wire logic [7:0]  paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error
  output logic             irq,              // Level interrupt
  input  wire logic        scl_in,           // Serial clock pin
  input  wire logic        sda_in,           // Serial data pin level
  output logic             sda_out,          // Serial data drive value
  output logic             sda_oe,           // Serial data drive enable
  output logic             event_output_pin, // Event output drive value
  output logic             event_output_oe   // Event output drive enable
);
  import igpo_pkg::*;

  igpo_line_if lines ();

  igpo_filter #(.FILT_CYC(FILT_CYC)) u_filter (
    .clk     (clk),
    .reset_n (reset_n),
    .scl_pin (scl_in),
    .sda_pin (sda_in),
    .lines   (lines)
  );

  function automatic logic mode_is(input igpo_mode_t m, input logic [3:0] code);
    return m == code;
  endfunction

  // Register state
  logic [7:0]   cfg_r, txd_r, rxd_r;
  logic [4:0]   stat_r, mask_r, stat_set, stat_clr;
  logic [9:0]   cmd_pulse;
  logic [31:0]  prdata_r, rd_nxt;
  logic         pready_r, pslverr_r, irq_r, apb_take, apb_wr, addr_ok;
  // Serial core state
  igpo_state_t  state_r;
  logic [7:0]   sr_r;
  logic [3:0]   bit_cnt_r;
  logic         rw_r, nack_r, sda_oe_r, scl_d_r, sda_d_r;
  logic         scl_rise, scl_fall, start_det, stop_det, addr_match;
  // Event output state
  logic         i2c_sess_r, rf_sess_r, answer_r, i2c_intr_r, rf_msg_r;
  logic [31:0]  i2c_wip_cnt_r, rf_wip_cnt_r, pulse_cnt_r;
  logic         i2c_wip, rf_wip, rf_pulse, low_wired, low_rf, gpo_oe_r, low_level_r;
  igpo_mode_t   mode_w, mode_rf;

  // APB slave: one wait state, write and read taken on the pready edge
  assign apb_take = psel & penable & pready_r;
  assign apb_wr   = apb_take & pwrite;

  always_comb begin
    addr_ok = 1'b1;
    rd_nxt  = 32'h0;
    unique case (paddr)
      `IGPO_OFS_CFG:   rd_nxt = {24'h0, cfg_r};
      `IGPO_OFS_CMD:   rd_nxt = 32'h0;
      `IGPO_OFS_STAT:  rd_nxt = {27'h0, stat_r};
      `IGPO_OFS_MASK:  rd_nxt = {27'h0, mask_r};
      `IGPO_OFS_STATE: rd_nxt = {21'h0, gpo_oe_r, rf_msg_r, rf_pulse, i2c_intr_r, answer_r,
                                 rf_wip, i2c_wip, rf_sess_r, i2c_sess_r, sda_oe_r, rw_r};
      `IGPO_OFS_TXD:   rd_nxt = {24'h0, txd_r};
      `IGPO_OFS_RXD:   rd_nxt = {24'h0, rxd_r};
      default:         addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~addr_ok;
      if (psel & penable & ~pready_r) begin
        prdata_r <= (!pwrite && addr_ok) ? rd_nxt : 32'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r  <= `IGPO_CFG_RST;
      mask_r <= `IGPO_MASK_RST;
      txd_r  <= `IGPO_TXD_RST;
    end else if (apb_wr) begin
      if (paddr == `IGPO_OFS_CFG) cfg_r <= pwdata[7:0];
      if (paddr == `IGPO_OFS_MASK) mask_r <= pwdata[4:0];
      if (paddr == `IGPO_OFS_TXD) txd_r <= pwdata[7:0];
    end
  end

  // Command register bits act as one-cycle events
  assign cmd_pulse = (apb_wr && paddr == `IGPO_OFS_CMD) ? pwdata[9:0] : 10'h0;
  assign stat_clr  = (apb_wr && paddr == `IGPO_OFS_STAT) ? pwdata[4:0] : 5'h0;

  // Sticky status, a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_r <= 5'h0;
      irq_r  <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
      irq_r  <= |(((stat_r & ~stat_clr) | stat_set) & mask_r);
    end
  end

  // Start and stop seen on filtered lines only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= lines.scl;
      sda_d_r <= lines.sda;
    end
  end

  assign scl_rise  = lines.scl & ~scl_d_r;
  assign scl_fall  = ~lines.scl & scl_d_r;
  assign start_det = lines.scl & scl_d_r & sda_d_r & ~lines.sda;
  assign stop_det  = lines.scl & scl_d_r & ~sda_d_r & lines.sda;
  assign addr_match = (state_r == IGPO_ADDR) && scl_fall && (bit_cnt_r == 4'h8)
                      && (sr_r[7:1] == `IGPO_SELECT_CODE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= IGPO_IDLE;
      sr_r      <= 8'h0;
      bit_cnt_r <= 4'h0;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      sda_oe_r  <= 1'b0;
      rxd_r     <= 8'h0;
    end else if (start_det) begin
      state_r   <= IGPO_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r  <= 1'b0;
    end else if (stop_det) begin
      state_r  <= IGPO_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        IGPO_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        IGPO_ADDR, IGPO_WR_BYTE: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            sr_r      <= {sr_r[6:0], lines.sda};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            if (state_r == IGPO_WR_BYTE) begin
              rxd_r    <= sr_r;
              sda_oe_r <= 1'b1;
              state_r  <= IGPO_WR_ACK;
            end else if (addr_match) begin
              rw_r     <= sr_r[0];
              sda_oe_r <= 1'b1;
              state_r  <= IGPO_ADDR_ACK;
            end else begin
              state_r <= IGPO_IDLE;
            end
          end
        end
        IGPO_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              sr_r     <= txd_r;
              sda_oe_r <= ~txd_r[7];
              state_r  <= IGPO_RD_BYTE;
            end else begin
              sda_oe_r <= 1'b0;
              state_r  <= IGPO_WR_BYTE;
            end
          end
        end
        IGPO_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            state_r  <= IGPO_WR_BYTE;
          end
        end
        IGPO_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              sda_oe_r <= 1'b0;
              state_r  <= IGPO_RD_ACK;
            end else begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
              sr_r      <= {sr_r[6:0], 1'b0};
              sda_oe_r  <= ~sr_r[6];
            end
          end
        end
        IGPO_RD_ACK: begin
          if (scl_rise) begin
            nack_r <= lines.sda;
          end else if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (nack_r) begin
              state_r <= IGPO_IDLE;
            end else begin
              sr_r     <= txd_r;
              sda_oe_r <= ~txd_r[7];
              state_r  <= IGPO_RD_BYTE;
            end
          end
        end
      endcase
    end
  end

  // Serial and timer events into status
  assign stat_set[`IGPO_ST_ADDR]  = addr_match;
  assign stat_set[`IGPO_ST_BYTE]  = (state_r == IGPO_WR_BYTE) && scl_fall && (bit_cnt_r == 4'h8);
  assign stat_set[`IGPO_ST_STOP]  = stop_det && (state_r != IGPO_IDLE);
  assign stat_set[`IGPO_ST_WDONE] = (i2c_wip_cnt_r == 32'h1) || (rf_wip_cnt_r == 32'h1);
  assign stat_set[`IGPO_ST_PDONE] = (pulse_cnt_r == 32'h1);

  // Session flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      i2c_sess_r <= 1'b0;
      rf_sess_r  <= 1'b0;
    end else begin
      if (cmd_pulse[`IGPO_CMD_I2C_SESS]) begin
        i2c_sess_r <= 1'b1;
      end else if (cmd_pulse[`IGPO_CMD_I2C_REL]) begin
        i2c_sess_r <= 1'b0;
      end
      if (cmd_pulse[`IGPO_CMD_RF_SESS]) begin
        rf_sess_r <= 1'b1;
      end else if (cmd_pulse[`IGPO_CMD_RF_DESEL]) begin
        rf_sess_r <= 1'b0;
      end
    end
  end

  // Programming timers, one page per update
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      i2c_wip_cnt_r <= 32'h0;
      rf_wip_cnt_r  <= 32'h0;
      rf_msg_r      <= 1'b0;
    end else begin
      if (cmd_pulse[`IGPO_CMD_I2C_WRITE]) begin
        i2c_wip_cnt_r <= 32'(WRITE_CYC);
      end else if (i2c_wip_cnt_r != 32'h0) begin
        i2c_wip_cnt_r <= i2c_wip_cnt_r - 32'h1;
      end
      if (cmd_pulse[`IGPO_CMD_RF_WRITE] || cmd_pulse[`IGPO_CMD_RF_MSG]) begin
        rf_wip_cnt_r <= 32'(WRITE_CYC);
      end else if (rf_wip_cnt_r != 32'h0) begin
        rf_wip_cnt_r <= rf_wip_cnt_r - 32'h1;
      end
      if (cmd_pulse[`IGPO_CMD_RF_MSG]) begin
        rf_msg_r <= 1'b1;
      end else if (rf_wip_cnt_r == 32'h1) begin
        rf_msg_r <= 1'b0;
      end
    end
  end

  assign i2c_wip  = i2c_wip_cnt_r != 32'h0;
  assign rf_wip   = rf_wip_cnt_r != 32'h0;
  assign rf_pulse = pulse_cnt_r != 32'h0;

  // Answer ready and wired interrupt end at the next command's select byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      answer_r   <= 1'b0;
      i2c_intr_r <= 1'b0;
      pulse_cnt_r <= 32'h0;
    end else begin
      if (cmd_pulse[`IGPO_CMD_ANSWER]) begin
        answer_r <= 1'b1;
      end else if (addr_match) begin
        answer_r <= 1'b0;
      end
      if (cmd_pulse[`IGPO_CMD_I2C_INTR]) begin
        i2c_intr_r <= 1'b1;
      end else if (addr_match) begin
        i2c_intr_r <= 1'b0;
      end
      if (cmd_pulse[`IGPO_CMD_RF_INTR]) begin
        pulse_cnt_r <= 32'(PULSE_CYC);
      end else if (rf_pulse) begin
        pulse_cnt_r <= pulse_cnt_r - 32'h1;
      end
    end
  end

  // Nibble select per side
  assign mode_w  = cfg_r[3:0];
  assign mode_rf = cfg_r[7:4];

  always_comb begin
    low_wired = (mode_is(mode_w, `IGPO_MODE_SESSION) && i2c_sess_r)
              | (mode_is(mode_w, `IGPO_MODE_WIP)     && i2c_wip)
              | (mode_is(mode_w, `IGPO_MODE_ANSWER)  && answer_r)
              | (mode_is(mode_w, `IGPO_MODE_INTR)    && i2c_intr_r);
    low_rf    = (mode_is(mode_rf, `IGPO_MODE_SESSION) && rf_sess_r)
              | (mode_is(mode_rf, `IGPO_MODE_WIP)     && rf_wip)
              | (mode_is(mode_rf, `IGPO_MODE_ANSWER)  && rf_msg_r)
              | (mode_is(mode_rf, `IGPO_MODE_INTR)    && rf_pulse);
  end

  // Open drain: enable asserted only to pull low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gpo_oe_r <= 1'b0;
    end else begin
      gpo_oe_r <= low_wired | low_rf;
    end
  end

  // Drive values are held low in a flop so no pin is ever driven high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_level_r <= 1'b0;
    end else begin
      low_level_r <= 1'b0;
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign irq              = irq_r;
  assign sda_out          = low_level_r;
  assign sda_oe           = sda_oe_r;
  assign event_output_pin = low_level_r;
  assign event_output_oe  = gpo_oe_r;
endmodule

//--- tb/igpo_top_sva.sv
// Checker on the ports of the select and event output top.
// Assumes one clock domain and the APB map of the hand-over.
`timescale 1ns/1ps
`include "igpo_defs.svh"
module igpo_top_sva #(
  parameter int WRITE_CYC = 20,
  parameter int PULSE_CYC = 10
) (
  input wire logic        clk,              // Clock
  input wire logic        reset_n,          // Reset, active low
  input wire logic        psel,             // APB select
  input wire logic        penable,          // APB enable
  input wire logic        pwrite,           // APB direction
  input wire logic [7:0]  paddr,            // APB address
  input wire logic [31:0] pwdata,           // APB write data
  input wire logic [31:0] prdata,           // APB read data
  input wire logic        pready,           // APB ready
  input wire logic        pslverr,          // APB error
  input wire logic        irq,              // Interrupt
  input wire logic        scl_in,           // Serial clock
  input wire logic        sda_in,           // Serial data
  input wire logic        sda_out,          // Data drive value
  input wire logic        sda_oe,           // Data drive enable
  input wire logic        event_output_pin, // Output drive value
  input wire logic        event_output_oe   // Output drive enable
);
  logic [7:0] cfg_r;
  int         hi_cnt_r;
  logic       wr_ack;
  assign wr_ack = psel && penable && pready && pwrite;
  // Shadow of the output setting
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      cfg_r <= 8'h00;
    else if (wr_ack && paddr == `IGPO_OFS_CFG)
      cfg_r <= pwdata[7:0];
  end
  // Length of the current low drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      hi_cnt_r <= 0;
    else
      hi_cnt_r <= event_output_oe ? hi_cnt_r + 1 : 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_cmd(logic [7:0] c, int b);
    wr_ack && paddr == `IGPO_OFS_CMD && cfg_r == c && pwdata[b];
  endsequence
  property p_open_drain; event_output_pin == 1'h0 && sda_out == 1'h0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("output driven high");
  property p_sess_on; s_cmd(8'h01, 0) |-> ##2 event_output_oe; endproperty
  a_sess_on: assert property (p_sess_on) else $error("session not signalled");
  property p_sess_off; s_cmd(8'h01, 1) |-> ##2 !event_output_oe; endproperty
  a_sess_off: assert property (p_sess_off) else $error("release not signalled");
  property p_wip_on; s_cmd(8'h02, 4) |-> ##2 event_output_oe; endproperty
  a_wip_on: assert property (p_wip_on) else $error("write not signalled");
  property p_msg_on; s_cmd(8'h30, 9) |-> ##2 event_output_oe; endproperty
  a_msg_on: assert property (p_msg_on) else $error("message update not signalled");
  property p_wip_len; $fell(event_output_oe) && cfg_r == 8'h02 |-> hi_cnt_r == WRITE_CYC; endproperty
  a_wip_len: assert property (p_wip_len) else $error("write low time wrong");
  property p_pulse_len; $fell(event_output_oe) && cfg_r == 8'h40 |-> hi_cnt_r == PULSE_CYC; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("interrupt pulse length wrong");
  property p_ack_low; $rose(sda_oe) |-> !scl_in; endproperty
  a_ack_low: assert property (p_ack_low) else $error("data driven with clock high");
endmodule
bind igpo_top igpo_top_sva #(.WRITE_CYC(WRITE_CYC), .PULSE_CYC(PULSE_CYC)) u_sva (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .event_output_pin(event_output_pin),
  .event_output_oe(event_output_oe)
);

//--- tb/igpo_i2c_master.sv
// Behavioural serial bus master for the clock and data lines.
// Assumes pull-ups on both lines; changes lines on rising clk edges.
`timescale 1ns/1ps
module igpo_i2c_master (
  input  wire logic clk,  // System clock
  input  wire logic sda,  // Resolved data line
  output logic      scl,  // Clock line, 1 released
  output logic      sda_o // Data drive, 1 released
);
  initial begin
    scl = 1'h1;
    sda_o = 1'h1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    hold(1);
    sda_o <= 1'h0;
    hold(20);
    scl <= 1'h0;
  endtask
  task automatic bit_out(input logic v);
    hold(10);
    sda_o <= v;
    hold(10);
    scl <= 1'h1;
    hold(20);
    scl <= 1'h0;
  endtask
  task automatic send(input logic [7:0] d, output logic a);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    hold(10);
    sda_o <= 1'h1;
    hold(10);
    scl <= 1'h1;
    hold(10);
    a = sda;
    hold(10);
    scl <= 1'h0;
  endtask
  task automatic stop();
    hold(10);
    sda_o <= 1'h0;
    hold(10);
    scl <= 1'h1;
    hold(20);
    sda_o <= 1'h1;
    hold(20);
  endtask
  // Short low pulse on data while clock is high
  task automatic glitch();
    hold(1);
    sda_o <= 1'h0;
    hold(3);
    sda_o <= 1'h1;
    hold(20);
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench of the select and event output top.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "igpo_defs.svh"
module tb;
  localparam int WCYC = 20;
  localparam int PCYC = 10;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        sda_in, sda_out, sda_oe, pin, oe, scl, sda_m, ack, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          fails, n_checks;
  assign sda_in = sda_m & ~sda_oe;
  igpo_top #(.WRITE_CYC(WCYC), .PULSE_CYC(PCYC), .FILT_CYC(4)) uut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .scl_in(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .event_output_pin(pin), .event_output_oe(oe)
  );
  igpo_i2c_master m (.clk(clk), .sda(sda_in), .scl(scl), .sda_o(sda_m));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    // Values read here are those sampled at this rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20)
      fails++;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'h0, a, 32'h0);
    chk(nm, ex, q);
  endtask
  task automatic cmd_oe(input logic [7:0] c, input int b, input logic ex);
    apb(1'h1, `IGPO_OFS_CFG, {24'h0, c});
    apb(1'h1, `IGPO_OFS_CMD, 32'h1 << b);
    wt(2);
    chk("event_oe", {31'h0, ex}, {31'h0, oe});
  endtask
  task automatic t_regs();
    rd("cfg", `IGPO_OFS_CFG, 32'h0);
    rd("mask", `IGPO_OFS_MASK, 32'h0);
    rd("cmd", `IGPO_OFS_CMD, 32'h0);
    apb(1'h1, 8'h40, 32'hFF);
    chk("slverr", 32'h1, {31'h0, e});
    $display("test regs done");
  endtask
  task automatic t_session();
    logic [7:0] c [6] = '{8'h01, 8'h01, 8'h10, 8'h10, 8'h10, 8'h01};
    int         b [6] = '{0, 1, 2, 3, 0, 1};
    logic [5:0] x = 6'h05;
    for (int i = 0; i < 6; i++) begin
      cmd_oe(c[i], b[i], x[i]);
      wt(40);
      chk("event_oe_hold", {31'h0, x[i]}, {31'h0, oe});
    end
    chk("pin", 32'h0, {31'h0, pin});
    rd("cfg", `IGPO_OFS_CFG, 32'h01);
    $display("test session done");
  endtask
  task automatic t_len();
    logic [7:0] c [4] = '{8'h02, 8'h20, 8'h30, 8'h40};
    int         b [4] = '{4, 5, 9, 8};
    int         ln [4] = '{WCYC, WCYC, WCYC, PCYC};
    int         n;
    for (int i = 0; i < 4; i++) begin
      cmd_oe(c[i], b[i], 1'h1);
      n = 0;
      while (oe === 1'h1 && n < 1000) begin
        wt(1);
        n++;
      end
      chk("low_len", ln[i], n);
    end
    $display("test length done");
  endtask
  task automatic t_irq();
    apb(1'h1, `IGPO_OFS_STAT, 32'h1F);
    apb(1'h1, `IGPO_OFS_MASK, 32'h0);
    cmd_oe(8'h40, 8, 1'h1);
    wt(2 * PCYC);
    rd("status", `IGPO_OFS_STAT, 32'h10);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'h1, `IGPO_OFS_MASK, 32'h10);
    wt(3);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'h1, `IGPO_OFS_STAT, 32'h10);
    wt(3);
    chk("irq_clear", 32'h0, {31'h0, irq});
    rd("status_clear", `IGPO_OFS_STAT, 32'h0);
    $display("test irq done");
  endtask
  task automatic t_serial();
    logic [7:0] c [2] = '{8'h03, 8'h04};
    int         b [2] = '{6, 7};
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, `IGPO_OFS_STAT, 32'h1F);
      cmd_oe(c[i], b[i], 1'h1);
      m.glitch();
      rd("glitch_status", `IGPO_OFS_STAT, 32'h0);
      m.start();
      m.send(8'hAE, ack);
      chk("nack", 32'h1, {31'h0, ack});
      chk("event_oe_kept", 32'h1, {31'h0, oe});
      m.stop();
      m.start();
      m.send({`IGPO_SELECT_CODE, 1'h0}, ack);
      chk("ack", 32'h0, {31'h0, ack});
      m.stop();
      chk("event_oe_release", 32'h0, {31'h0, oe});
    end
    $display("test serial done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
  initial begin
    fails = 0;
    n_checks = 0;
    reset_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    repeat (10) @(posedge clk);
    t_regs();
    t_session();
    t_len();
    t_irq();
    t_serial();
    wrap_up();
  end
endmodule
